/* rtl/sacr_config.sv */
`timescale 1ns/1ps
module sacr_config (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic serial_clk,
  input wire logic cs_n,
  input wire logic data_in,
  input wire logic [11:0] result_data,
  output logic data_out,
  output logic [11:0] conversion_config,
  output logic [2:0] mux_channel,
  output logic range_half,
  output logic coding_binary,
  output logic [1:0] power_mode,
  output logic power_down,
  output logic wake_pending,
  output logic [1:0] seq_mode,
  output logic [7:0] channel_list,
  output logic [2:0] report_channel,
  output logic config_error
);
  sacr_frame_if frame();
  logic [4:0] edge_count;
  logic [2:0] conv_channel;
  logic mux_toggle;
  logic seq_was_consec;

  sacr_link u_link (
    .serial_clk(serial_clk),
    .rst_n(rst_n),
    .cs_n(cs_n),
    .data_in(data_in),
    .report_channel(report_channel),
    .report_data(result_data),
    .data_out(data_out),
    .edge_count(edge_count),
    .frame(frame)
  );

  // Mux event on the link clock, crossed as a toggle
  always_ff @(negedge serial_clk or negedge rst_n) begin
    if (!rst_n) begin
      mux_toggle <= 1'b0;
    end else if (!cs_n && edge_count == sacr_pkg::MUX_EDGE - 5'h0_001) begin
      mux_toggle <= ~mux_toggle;
    end
  end

  logic frame_tog_s;
  logic mux_tog_s;
  logic [11:0] word_s;
  logic frame_tog_d;
  logic frame_tog_dd;
  logic mux_tog_d;
  sacr_sync #(.WIDTH(2)) u_sync_evt (
    .clk(ref_clk),
    .rst_n(rst_n),
    .d({frame.toggle, mux_toggle}),
    .q({frame_tog_s, mux_tog_s})
  );
  // Word bits move with the toggle; the event waits one more stage so every bit settles
  sacr_sync #(.WIDTH(12)) u_sync_word (
    .clk(ref_clk),
    .rst_n(rst_n),
    .d(frame.word),
    .q(word_s)
  );

  wire logic frame_evt = frame_tog_d ^ frame_tog_dd;
  wire logic mux_evt = mux_tog_s ^ mux_tog_d;
  wire logic list_pending = seq_mode == sacr_pkg::SACR_SEQ_LOAD_LIST;
  wire logic write_gate = word_s[sacr_pkg::BIT_UPDATE];
  wire logic load_cfg = frame_evt && write_gate && !list_pending;
  wire logic load_list = frame_evt && list_pending;
  wire logic [1:0] next_seq = {word_s[sacr_pkg::BIT_AUTO_CYCLE],
                               word_s[sacr_pkg::BIT_LIST_ACCESS]};
  wire logic [2:0] cfg_chan = conversion_config[sacr_pkg::BIT_CHAN_HI:sacr_pkg::BIT_CHAN_LO];
  wire logic seq_consec = seq_mode == sacr_pkg::SACR_SEQ_CONSECUTIVE;
  // Entering consecutive mode restarts the walk at channel 0
  wire logic seq_at_end = !seq_was_consec || conv_channel == cfg_chan;
  wire logic [2:0] next_channel = seq_consec ?
                                  (seq_at_end ? 3'h0 : conv_channel + 3'h1) : cfg_chan;
  wire logic [1:0] pm_bits = conversion_config[sacr_pkg::BIT_PM_HI:sacr_pkg::BIT_PM_LO];
  localparam int WAKE_W = $clog2(sacr_pkg::WAKE_CYCLES + 1);
  logic [WAKE_W-1:0] wake_count;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_tog_d <= 1'b0;
      frame_tog_dd <= 1'b0;
      mux_tog_d <= 1'b0;
      conversion_config <= sacr_pkg::CFG_RESET;
      channel_list <= sacr_pkg::LIST_RESET;
    end else begin
      frame_tog_d <= frame_tog_s;
      frame_tog_dd <= frame_tog_d;
      mux_tog_d <= mux_tog_s;
      if (load_cfg) begin
        // Update gate itself is not stored state; keep it set
        conversion_config <= {1'b1, word_s[10:0]};
      end
      if (load_list) begin
        channel_list <= word_s[11:4];
      end
    end
  end

  // Mode bits apply from the next conversion onward
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      seq_mode <= sacr_pkg::SACR_SEQ_OFF;
      range_half <= 1'b0;
      coding_binary <= 1'b0;
      power_mode <= sacr_pkg::SACR_PM_NORMAL;
      config_error <= 1'b0;
    end else if (load_cfg) begin
      seq_mode <= next_seq;
      range_half <= word_s[sacr_pkg::BIT_RANGE];
      coding_binary <= word_s[sacr_pkg::BIT_CODING];
      power_mode <= word_s[sacr_pkg::BIT_PM_HI:sacr_pkg::BIT_PM_LO];
      config_error <= word_s[sacr_pkg::BIT_PM_HI:sacr_pkg::BIT_PM_LO] ==
                      sacr_pkg::SACR_PM_INVALID;
    end else if (load_list) begin
      seq_mode <= sacr_pkg::SACR_SEQ_OFF;
    end
  end

  // Channel moves at the mux edge; reported channel tracks the sample
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_channel <= 3'h0;
      mux_channel <= 3'h0;
      report_channel <= 3'h0;
      seq_was_consec <= 1'b0;
    end else if (mux_evt) begin
      // Next frame samples this channel, so its result carries this address
      report_channel <= next_channel;
      seq_was_consec <= seq_consec;
      conv_channel <= next_channel;
      mux_channel <= next_channel;
    end
  end

  // Auto shutdown sleeps after each frame and needs the wake time
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      power_down <= 1'b0;
      wake_pending <= 1'b0;
      wake_count <= '0;
    end else begin
      power_down <= pm_bits == sacr_pkg::SACR_PM_FULL_SHUTDOWN;
      if (pm_bits == sacr_pkg::SACR_PM_AUTO_SHUTDOWN && frame_evt) begin
        wake_count <= WAKE_W'(sacr_pkg::WAKE_CYCLES);
        wake_pending <= 1'b1;
      end else if (wake_count != '0) begin
        wake_count <= wake_count - WAKE_W'(1);
        wake_pending <= wake_count != WAKE_W'(1);
      end else begin
        wake_pending <= 1'b0;
      end
    end
  end
endmodule : sacr_config

/* rtl/sacr_frame_if.sv */
`timescale 1ns/1ps
interface sacr_frame_if;
  logic [11:0] word;
  logic toggle;
  modport src (output word, output toggle);
  modport dst (input word, input toggle);
endinterface : sacr_frame_if

/* rtl/sacr_link.sv */
`timescale 1ns/1ps
module sacr_link (
  input wire logic serial_clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic data_in,
  input wire logic [2:0] report_channel,
  input wire logic [11:0] report_data,
  output logic data_out,
  output logic [4:0] edge_count,
  sacr_frame_if.src frame
);
  // Shift state lives only on the link clock; cs_n high clears it.
  logic [11:0] shift_in;
  logic [15:0] shift_out;
  logic frame_toggle;
  wire logic [15:0] out_word = {1'b0, report_channel, report_data};
  wire logic capturing = edge_count < sacr_pkg::CAPTURE_LAST;
  wire logic word_done = edge_count == sacr_pkg::CAPTURE_LAST - 5'h0_001;

  always_ff @(negedge serial_clk or posedge cs_n) begin
    if (cs_n) begin
      edge_count <= '0;
      shift_in <= '0;
    end else begin
      if (edge_count != sacr_pkg::FRAME_END) begin
        edge_count <= edge_count + 5'h0_001;
      end
      if (capturing) begin
        shift_in <= {shift_in[10:0], data_in};
      end
    end
  end

  always_ff @(negedge serial_clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_toggle <= 1'b0;
      frame.word <= '0;
    end else if (!cs_n && word_done) begin
      frame.word <= {shift_in[10:0], data_in};
      frame_toggle <= ~frame_toggle;
    end
  end
  assign frame.toggle = frame_toggle;

  // Result shifts out on rising edges while config shifts in on falling.
  always_ff @(posedge serial_clk or posedge cs_n) begin
    if (cs_n) begin
      shift_out <= '0;
      data_out <= 1'b0;
    end else begin
      // Leading zero stands from chip select; first rising edge follows falling edge one
      data_out <= (edge_count == 5'h0_001) ? out_word[14] : shift_out[15];
      shift_out <= (edge_count == 5'h0_001) ? {out_word[13:0], 2'b00} : {shift_out[14:0], 1'b0};
    end
  end
endmodule : sacr_link

/* rtl/sacr_pkg.sv */
package sacr_pkg;
  localparam int FRAME_BITS = 16;
  localparam int CFG_BITS = 12;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] CAPTURE_LAST = 5'h0_00c;
  localparam logic [CNT_W-1:0] MUX_EDGE = 5'h0_00e;
  localparam logic [CNT_W-1:0] FRAME_END = 5'h0_010;
  localparam int BIT_UPDATE = 11;
  localparam int BIT_AUTO_CYCLE = 10;
  localparam int BIT_IGNORED_HI = 9;
  localparam int BIT_CHAN_HI = 8;
  localparam int BIT_CHAN_LO = 6;
  localparam int BIT_PM_HI = 5;
  localparam int BIT_PM_LO = 4;
  localparam int BIT_LIST_ACCESS = 3;
  localparam int BIT_IGNORED_LO = 2;
  localparam int BIT_RANGE = 1;
  localparam int BIT_CODING = 0;
  localparam logic [CFG_BITS-1:0] CFG_RESET = 12'h0_830;
  localparam logic [7:0] LIST_RESET = 8'h0_0ff;
  localparam real WAKE_TIME_NS = 1000.0;
  localparam real REF_PERIOD_NS = 5.0;
  localparam int WAKE_CYCLES = int'(WAKE_TIME_NS / REF_PERIOD_NS);
  typedef enum logic [1:0] {
    SACR_PM_INVALID = 2'h0,
    SACR_PM_AUTO_SHUTDOWN = 2'h1,
    SACR_PM_FULL_SHUTDOWN = 2'h2,
    SACR_PM_NORMAL = 2'h3
  } sacr_power_type;
  typedef enum logic [1:0] {
    SACR_SEQ_OFF = 2'h0,
    SACR_SEQ_LOAD_LIST = 2'h1,
    SACR_SEQ_KEEP = 2'h2,
    SACR_SEQ_CONSECUTIVE = 2'h3
  } sacr_seq_type;
endpackage : sacr_pkg

/* rtl/sacr_sync.sv */
`timescale 1ns/1ps
module sacr_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] stage;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage <= '0;
      q <= '0;
    end else begin
      stage <= d;
      q <= stage;
    end
  end
endmodule : sacr_sync

/* tb/sacr_config_checker.sv */
`timescale 1ns/1ps
module sacr_config_checker (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic [11:0] conversion_config,
  input wire logic [2:0] mux_channel,
  input wire logic range_half,
  input wire logic coding_binary,
  input wire logic [1:0] power_mode,
  input wire logic power_down,
  input wire logic wake_pending,
  input wire logic [7:0] channel_list
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_gate; conversion_config[11]; endproperty
  a_gate: assert property (p_gate) else $error("gate bit low in config");
  property p_range; $changed(conversion_config) |-> ##[0:3] range_half == conversion_config[1];
  endproperty
  a_range: assert property (p_range) else $error("range bit not applied");
  property p_coding; $changed(conversion_config) |-> ##[0:3] coding_binary == conversion_config[0];
  endproperty
  a_coding: assert property (p_coding) else $error("coding bit not applied");
  property p_pmode; $stable(conversion_config)[*4] |-> power_mode == conversion_config[5:4];
  endproperty
  a_pmode: assert property (p_pmode) else $error("power bits not decoded");
  property p_pdown; $stable(power_mode)[*4] ##0 power_mode != 2'h1 |->
    power_down == (power_mode == 2'h2); endproperty
  a_pdown: assert property (p_pdown) else $error("shutdown level wrong");
  property p_wake; $rose(wake_pending) |-> $past(power_mode) == 2'h1; endproperty
  a_wake: assert property (p_wake) else $error("wake outside auto mode");
  property p_cfg_frame; $changed(conversion_config) |-> !cs_n; endproperty
  a_cfg_frame: assert property (p_cfg_frame) else $error("config moved off frame");
  property p_mux_frame; $changed(mux_channel) |-> !cs_n; endproperty
  a_mux_frame: assert property (p_mux_frame) else $error("mux moved off frame");
  property p_list_frame; $changed(channel_list) |-> !cs_n; endproperty
  a_list_frame: assert property (p_list_frame) else $error("list moved off frame");
  c_wake: cover property (wake_pending);
  c_pdown: cover property (power_down);
  c_list: cover property ($changed(channel_list));
endmodule : sacr_config_checker

/* tb/sacr_host.sv */
`timescale 1ns/1ps
module sacr_host (
  output logic serial_clk,
  output logic cs_n,
  output logic data_in,
  input wire logic data_out
);
  initial begin
    serial_clk = 1'b1;
    cs_n = 1'b1;
    data_in = 1'b0;
  end
  // Clock stands high between frames; input line inverted before chip select is released
  task automatic send(input logic [15:0] word, output logic [15:0] rx);
    #17.3 cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      data_in = word[i];
      #31.25 serial_clk = 1'b0;
      rx[i] = data_out;
      #62.5 serial_clk = 1'b1;
      #31.25;
    end
    data_in = ~data_in;
    #40 cs_n = 1'b1;
    #300;
  endtask : send
endmodule : sacr_host

/* tb/tb.sv */
`timescale 1ns/1ps
module tb;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] result_data = 12'h0_000;
  logic serial_clk, cs_n, data_in, data_out;
  int errors = 0;
  int cmp_count = 0;
  always #2.5 ref_clk = ~ref_clk;
  sacr_host host (.serial_clk, .cs_n, .data_in, .data_out);
  sacr_config DUT (.ref_clk, .rst_n, .serial_clk, .cs_n, .data_in, .result_data, .data_out,
    .conversion_config(), .mux_channel(), .range_half(), .coding_binary(), .power_mode(),
    .power_down(), .wake_pending(), .seq_mode(), .channel_list(), .report_channel(),
    .config_error());
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic t_reset();
    chk("config", 16'h0_830, 16'(DUT.conversion_config));
    chk("pmode", 16'h0_003, 16'(DUT.power_mode));
    chk("err", 16'h0_000, 16'(DUT.config_error));
    chk("list", 16'h0_0ff, 16'(DUT.channel_list));
  endtask : t_reset
  task automatic t_write();
    logic [15:0] rx;
    host.send(16'h8_b3f, rx);
    chk("config", 16'h0_8b3, 16'(DUT.conversion_config));
    chk("mux", 16'h0_002, 16'(DUT.mux_channel));
    chk("range", 16'h0_001, 16'(DUT.range_half));
    chk("coding", 16'h0_001, 16'(DUT.coding_binary));
  endtask : t_write
  task automatic t_gate();
    logic [15:0] rx;
    @(posedge ref_clk);
    #1 result_data = 12'ha_5c;
    host.send(16'h7_fff, rx);
    chk("config", 16'h0_8b3, 16'(DUT.conversion_config));
    chk("report", 16'h2_a5c, rx);
    chk("rchan", 16'h0_002, 16'(DUT.report_channel));
  endtask : t_gate
  task automatic t_power();
    logic [15:0] rx;
    host.send(16'h8_200, rx);
    chk("pdown", 16'h0_001, 16'(DUT.power_down));
    chk("range", 16'h0_000, 16'(DUT.range_half));
    chk("coding", 16'h0_000, 16'(DUT.coding_binary));
    host.send(16'h8_100, rx);
    host.send(16'h0_000, rx);
    chk("wake", 16'h0_001, 16'(DUT.wake_pending));
    host.send(16'h8_300, rx);
    chk("pdown", 16'h0_000, 16'(DUT.power_down));
    chk("err", 16'h0_000, 16'(DUT.config_error));
  endtask : t_power
  task automatic t_list();
    logic [15:0] rx;
    host.send(16'h8_380, rx);
    chk("seq", 16'h0_001, 16'(DUT.seq_mode));
    host.send(16'h8_000, rx);
    chk("config", 16'h0_838, 16'(DUT.conversion_config));
    chk("list", 16'h0_080, 16'(DUT.channel_list));
    host.send(16'hd_f80, rx);
    chk("seq", 16'h0_003, 16'(DUT.seq_mode));
    for (int i = 0; i < 3; i++) begin
      host.send(16'h0_000, rx);
      chk("chan", 16'(i), 16'(rx[14:12]));
    end
  endtask : t_list
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (12) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge ref_clk);
    t_reset();
    t_write();
    t_gate();
    t_power();
    t_list();
    print_verdict();
  end
  // About three and a half times the expected run
  initial begin
    #100000;
    errors++;
    print_verdict();
  end
endmodule : tb
bind sacr_config sacr_config_checker u_chk (.ref_clk, .rst_n, .cs_n, .conversion_config,
  .mux_channel, .range_half, .coding_binary, .power_mode, .power_down, .wake_pending,
  .channel_list);
